// File: abce_pkg.sv
// How it works
// - add, and, compare, subtract take accumulator plus memory or immediate byte.
// - clear, decrement, increment may address any of 256 data-space bytes.
// - complement, rotate-left-through-carry, shift-left act on accumulator only.
// - conditional branches jump only when condition holds, else fall through.
// - short branch uses 5-bit displacement spanning -15 to +16.
// - bit-test branch uses 8-bit displacement spanning -126 to +129.
// - bit-test branch copies tested bit into carry, zero untouched.
// - bit operations reach any bit of any data-space byte.
// - bit set or clear forces one bit, flags untouched.
// - jump and call carry a 12-bit target over whole program space.
// - control group: no-op, return, interrupt return, stop, wait; interrupt_return_op restores flags.
package abce_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 12;
   localparam int ADDR_W = 8;
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [3:0] CYC_ALU = 4'h4;
   localparam logic [3:0] CYC_SHORT = 4'h2;
   localparam logic [3:0] CYC_BTB = 4'h5;
   localparam logic [3:0] CYC_JUMP = 4'h4;
   // bit-test displacement base: instruction address plus two, reach -126..+129
   localparam logic [PC_W-1:0] BTB_BASE = 12'h002;

   typedef enum logic [4:0] {
      ABCE_OP_ADD = 5'h00, ABCE_OP_AND = 5'h01, compare_op = 5'h02, ABCE_OP_SUB = 5'h03,
      clear_op = 5'h04, decrement_op = 5'h05, ABCE_OP_INC = 5'h06,
      complement_op = 5'h07, rotate_left_carry_op = 5'h08, shift_left_arith_op = 5'h09,
      branch_if_carry = 5'h0A, branch_if_no_carry = 5'h0B, branch_if_zero = 5'h0C,
      branch_if_nonzero = 5'h0D, branch_if_bit_clear = 5'h0E, branch_if_bit_set = 5'h0F,
      ABCE_OP_BSET = 5'h10, bit_clear_op = 5'h11, long_jump_op = 5'h12, ABCE_OP_CALL = 5'h13,
      no_operation = 5'h14, ABCE_OP_RET = 5'h15, interrupt_return_op = 5'h16,
      ABCE_OP_STOP = 5'h17, ABCE_OP_WAIT = 5'h18
   } abce_op_t;

   // decoded instruction from the fetch unit
   typedef struct packed {
      abce_op_t op;
      logic use_imm;             // second operand is the immediate byte
      logic dst_acc;             // clear/inc/dec target the accumulator
      logic [ADDR_W-1:0] addr;   // data-space byte address
      logic [DATA_W-1:0] imm;    // immediate byte
      logic [2:0] bit_sel;       // bit index
      logic [4:0] disp5;         // sign bit + 4-bit span
      logic [7:0] disp8;         // bit-test displacement
      logic [PC_W-1:0] target;   // long jump/call target
   } abce_instr_t;

   // data-space write request
   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } abce_wr_t;
endpackage

// File: abce_exec.sv
`timescale 1ns/1ps
`default_nettype none
module abce_exec #(
   parameter int DATA_W = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic instr_valid,
   output logic instr_ready,
   input wire abce_pkg::abce_instr_t instr,
   input wire logic [abce_pkg::PC_W-1:0] instr_pc,
   input wire logic [7:0] mem_rdata,
   output logic [7:0] mem_raddr,
   output abce_pkg::abce_wr_t mem_wr_ff,
   input wire logic [abce_pkg::PC_W-1:0] ret_addr,
   input wire logic interrupt_return_op_z,
   input wire logic interrupt_return_op_c,
   output logic [7:0] acc_ff,
   output logic zero_ff,
   output logic carry_ff,
   output logic pc_load_ff,
   output logic [abce_pkg::PC_W-1:0] pc_target_ff,
   output logic push_ff,
   output logic pop_ff,
   output logic stop_ff,
   output logic wait_ff,
   output logic done_ff
);
   // refuse widths the datapath cannot serve
   if (DATA_W != 8) begin : g_width_chk
      $error("abce_exec serves only 8-bit data");
   end

   typedef enum logic [1:0] {
      ABCE_IDLE = 2'b01,
      ABCE_BUSY = 2'b10
   } abce_state_t;

   abce_state_t state_ff;
   abce_pkg::abce_instr_t cur_ff;
   logic [abce_pkg::PC_W-1:0] ipc_ff;
   logic [3:0] cnt_ff;
   logic last;
   logic [7:0] opnd;
   logic [7:0] res;
   logic res_c;
   logic wr_acc, upd_z, upd_c, tbit;
   logic [7:0] mem_res;
   logic take;

   function automatic logic [3:0] abce_cycles(input abce_pkg::abce_op_t op);
      case (op)
         abce_pkg::branch_if_carry, abce_pkg::branch_if_no_carry,
         abce_pkg::branch_if_zero, abce_pkg::branch_if_nonzero,
         abce_pkg::no_operation, abce_pkg::ABCE_OP_RET,
         abce_pkg::interrupt_return_op, abce_pkg::ABCE_OP_STOP,
         abce_pkg::ABCE_OP_WAIT: abce_cycles = abce_pkg::CYC_SHORT;
         abce_pkg::branch_if_bit_clear, abce_pkg::branch_if_bit_set:
            abce_cycles = abce_pkg::CYC_BTB;
         abce_pkg::long_jump_op, abce_pkg::ABCE_OP_CALL: abce_cycles = abce_pkg::CYC_JUMP;
         default: abce_cycles = abce_pkg::CYC_ALU;
      endcase
   endfunction

   // relative target: pc plus or minus sign-extended displacement
   function automatic logic [11:0] abce_rel(input logic [11:0] pc, input logic [11:0] d);
      abce_rel = pc + d;
   endfunction

   assign instr_ready = (state_ff == ABCE_IDLE);
   assign last = (state_ff == ABCE_BUSY) && (cnt_ff == 4'h1);
   assign mem_raddr = (state_ff == ABCE_IDLE) ? instr.addr : cur_ff.addr;
   assign tbit = mem_rdata[cur_ff.bit_sel];

   // operand select and result datapath
   always_comb begin
      opnd = cur_ff.use_imm ? cur_ff.imm : mem_rdata;
      res = acc_ff;
      res_c = carry_ff;
      wr_acc = 1'b0;
      upd_z = 1'b0;
      upd_c = 1'b0;
      mem_res = mem_rdata;
      take = 1'b0;
      case (cur_ff.op)
         abce_pkg::ABCE_OP_ADD: begin
            {res_c, res} = {1'b0, acc_ff} + {1'b0, opnd};
            wr_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1;
         end
         abce_pkg::ABCE_OP_AND: begin
            res = acc_ff & opnd;
            res_c = carry_ff;
            wr_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1;
         end
         abce_pkg::compare_op, abce_pkg::ABCE_OP_SUB: begin
            {res_c, res} = {1'b0, acc_ff} - {1'b0, opnd};
            wr_acc = (cur_ff.op == abce_pkg::ABCE_OP_SUB);
            upd_z = 1'b1; upd_c = 1'b1;
         end
         abce_pkg::clear_op: begin
            res = 8'h00;
            mem_res = 8'h00;
            wr_acc = cur_ff.dst_acc;
            upd_z = cur_ff.dst_acc; upd_c = cur_ff.dst_acc;
            res_c = 1'b0;
         end
         abce_pkg::decrement_op, abce_pkg::ABCE_OP_INC: begin
            mem_res = cur_ff.dst_acc ? acc_ff : mem_rdata; // accumulator or data byte
            mem_res = (cur_ff.op == abce_pkg::ABCE_OP_INC) ? mem_res + 8'h01
                                                           : mem_res - 8'h01;
            res = mem_res;
            wr_acc = cur_ff.dst_acc;
            upd_z = 1'b1;
         end
         abce_pkg::complement_op: begin
            res = ~acc_ff;
            res_c = acc_ff[7];
            wr_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1;
         end
         abce_pkg::rotate_left_carry_op: begin
            {res_c, res} = {acc_ff, carry_ff};
            wr_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1;
         end
         abce_pkg::shift_left_arith_op: begin
            {res_c, res} = {acc_ff, 1'b0};
            wr_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1;
         end
         abce_pkg::branch_if_carry: take = carry_ff;
         abce_pkg::branch_if_no_carry: take = !carry_ff;
         abce_pkg::branch_if_zero: take = zero_ff;
         abce_pkg::branch_if_nonzero: take = !zero_ff;
         abce_pkg::branch_if_bit_clear, abce_pkg::branch_if_bit_set: begin
            take = (cur_ff.op == abce_pkg::branch_if_bit_set) ? tbit : !tbit;
            res_c = tbit;
            upd_c = 1'b1;
         end
         abce_pkg::ABCE_OP_BSET: mem_res[cur_ff.bit_sel] = 1'b1;
         abce_pkg::bit_clear_op: mem_res[cur_ff.bit_sel] = 1'b0;
         default: take = 1'b0;
      endcase
   end

   // sequencing: accept, count down, retire
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_ff <= ABCE_IDLE;
         cnt_ff <= 4'h0;
         cur_ff <= '0;
         ipc_ff <= abce_pkg::PC_RESET;
      end else if (state_ff == ABCE_IDLE) begin
         if (instr_valid) begin
            state_ff <= ABCE_BUSY;
            cnt_ff <= abce_cycles(instr.op);
            cur_ff <= instr;
            ipc_ff <= instr_pc;
         end
      end else begin
         cnt_ff <= cnt_ff - 4'h1;
         if (last) state_ff <= ABCE_IDLE;
      end
   end

   // accumulator and flags, written in the last cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         acc_ff <= abce_pkg::ACC_RESET;
         zero_ff <= 1'b0;
         carry_ff <= 1'b0;
      end else if (last) begin
         if (wr_acc) acc_ff <= res;
         if (cur_ff.op == abce_pkg::interrupt_return_op) begin
            zero_ff <= interrupt_return_op_z;
            carry_ff <= interrupt_return_op_c;
         end else begin
            if (upd_z) zero_ff <= (res == 8'h00);
            if (upd_c) carry_ff <= res_c;
         end
      end
   end

   // data-space read-modify-write
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mem_wr_ff <= '0;
      end else begin
         mem_wr_ff.we <= last && !cur_ff.dst_acc &&
            (cur_ff.op inside {abce_pkg::clear_op, abce_pkg::decrement_op, abce_pkg::ABCE_OP_INC,
                               abce_pkg::ABCE_OP_BSET, abce_pkg::bit_clear_op});
         mem_wr_ff.addr <= cur_ff.addr;
         mem_wr_ff.data <= mem_res;
      end
   end

   // program flow outputs
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pc_load_ff <= 1'b0;
         pc_target_ff <= abce_pkg::PC_RESET;
         push_ff <= 1'b0;
         pop_ff <= 1'b0;
         stop_ff <= 1'b0;
         wait_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= last;
         pc_load_ff <= 1'b0;
         push_ff <= 1'b0;
         pop_ff <= 1'b0;
         stop_ff <= 1'b0;
         wait_ff <= 1'b0;
         if (last) begin
            case (cur_ff.op)
               abce_pkg::branch_if_carry, abce_pkg::branch_if_no_carry,
               abce_pkg::branch_if_zero, abce_pkg::branch_if_nonzero: begin
                  pc_load_ff <= take;
                  // sign bit set: backward by span, else forward by span plus one
                  pc_target_ff <= cur_ff.disp5[4] ?
                     abce_rel(ipc_ff, -{8'h00, cur_ff.disp5[3:0]}) :
                     abce_rel(ipc_ff, {8'h00, cur_ff.disp5[3:0]} + 12'h001);
               end
               abce_pkg::branch_if_bit_clear, abce_pkg::branch_if_bit_set: begin
                  pc_load_ff <= take;
                  // signed byte added to instruction address plus two
                  pc_target_ff <= abce_rel(ipc_ff + abce_pkg::BTB_BASE,
                                           {{4{cur_ff.disp8[7]}}, cur_ff.disp8});
               end
               abce_pkg::long_jump_op, abce_pkg::ABCE_OP_CALL: begin
                  pc_load_ff <= 1'b1;
                  pc_target_ff <= cur_ff.target;
                  push_ff <= (cur_ff.op == abce_pkg::ABCE_OP_CALL);
               end
               abce_pkg::ABCE_OP_RET, abce_pkg::interrupt_return_op: begin
                  pc_load_ff <= 1'b1;
                  pc_target_ff <= ret_addr;
                  pop_ff <= 1'b1;
               end
               abce_pkg::ABCE_OP_STOP: stop_ff <= 1'b1;
               abce_pkg::ABCE_OP_WAIT: wait_ff <= 1'b1;
               default: pc_load_ff <= 1'b0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: abce_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
module abce_exec_properties (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire abce_pkg::abce_instr_t instr,
   input wire logic [abce_pkg::PC_W-1:0] instr_pc,
   input wire logic [7:0] mem_rdata,
   input wire logic zero_ff,
   input wire logic carry_ff,
   input wire logic pc_load_ff,
   input wire logic [abce_pkg::PC_W-1:0] pc_target_ff,
   input wire logic done_ff
);
   logic take, sb, bt, tb, cnd, tok_ff, tbit_ff;
   logic [11:0] tgt, tgt_ff;
   // classify the offered instruction and work out its destination
   always_comb begin
      take = instr_valid && instr_ready;
      sb = instr.op inside {[5'h0A:5'h0D]};
      bt = instr.op inside {[5'h0E:5'h0F]};
      tb = mem_rdata[instr.bit_sel];
      cnd = (instr.op == abce_pkg::branch_if_carry) ? carry_ff :
            (instr.op == abce_pkg::branch_if_no_carry) ? !carry_ff :
            (instr.op == abce_pkg::branch_if_zero) ? zero_ff : !zero_ff;
      tgt = bt ? instr_pc + abce_pkg::BTB_BASE + {{4{instr.disp8[7]}}, instr.disp8} :
            !sb ? instr.target :
            instr.disp5[4] ? instr_pc - {8'h00, instr.disp5[3:0]} :
            instr_pc + {8'h00, instr.disp5[3:0]} + 12'h001;
   end
   // remember destination and tested bit of the accepted instruction
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tok_ff <= 1'b0;
      end else if (take) begin
         tok_ff <= sb || bt || instr.op inside {[5'h12:5'h13]};
      end
   end
   always_ff @(posedge clk) begin
      if (take) begin
         tgt_ff <= tgt;
         tbit_ff <= tb;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_ALU_BUSY:
   assert property (take && instr.op inside {[5'h00:5'h09], [5'h10:5'h13]}
      |=> !instr_ready [*4] ##1 instr_ready) else $error("alu busy span wrong");
   AST_SHORT_BUSY:
   assert property (take && (sb || instr.op inside {[5'h14:5'h18]})
      |=> !instr_ready [*2] ##1 instr_ready) else $error("short busy span wrong");
   AST_BTB_BUSY:
   assert property (take && bt |=> !instr_ready [*5] ##1 instr_ready) else $error("btb span");
   AST_DONE_AFTER:
   assert property ($rose(instr_ready) |-> ##[0:1] done_ff) else $error("no done after busy");
   AST_SHORT_KEEP:
   assert property (take && (sb || instr.op inside {5'h14, 5'h15, 5'h17, 5'h18})
      |=> ($stable(zero_ff) && $stable(carry_ff)) [*3]) else $error("flags moved");
   AST_BIT_KEEP:
   assert property (take && (instr.op inside {[5'h10:5'h13]} || instr.op == abce_pkg::clear_op
      && !instr.dst_acc) |=> ($stable(zero_ff) && $stable(carry_ff)) [*5]) else $error("flags");
   AST_BTB_CARRY:
   assert property (take && bt |-> ##6 carry_ff == tbit_ff && zero_ff == $past(zero_ff, 6))
      else $error("tested bit not in carry");
   AST_BTB_FALL:
   assert property (take && bt && tb == (instr.op == abce_pkg::branch_if_bit_clear)
      |-> ##2 !pc_load_ff [*5]) else $error("bit test branched wrongly");
   AST_SHORT_TAKE:
   assert property (take && sb && cnd |-> ##[2:4] pc_load_ff) else $error("branch not taken");
   AST_TARGET:
   assert property (pc_load_ff && tok_ff |-> pc_target_ff == tgt_ff) else $error("bad target");
endmodule
`default_nettype wire

// File: alu_branch_control_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module alu_branch_control_exec_test;
   logic clk, rst_b, instr_valid, instr_ready, interrupt_return_op_z, interrupt_return_op_c, zero_ff, carry_ff, c;
   logic pc_load_ff, push_ff, pop_ff, stop_ff, wait_ff, done_ff;
   abce_pkg::abce_instr_t instr, ins;
   abce_pkg::abce_wr_t mem_wr_ff;
   logic [11:0] instr_pc, ret_addr, pc_target_ff, pcv;
   logic [7:0] mem [256];
   logic [7:0] mem_rdata, mem_raddr, acc_ff;
   logic [4:0] pulses;
   int error_cnt = 0;
   int checked = 0;
   abce_exec u_dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
      .instr_ready(instr_ready), .instr(instr), .instr_pc(instr_pc), .mem_rdata(mem_rdata),
      .mem_raddr(mem_raddr), .mem_wr_ff(mem_wr_ff), .ret_addr(ret_addr), .interrupt_return_op_z(interrupt_return_op_z),
      .interrupt_return_op_c(interrupt_return_op_c), .acc_ff(acc_ff), .zero_ff(zero_ff), .carry_ff(carry_ff),
      .pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff), .push_ff(push_ff),
      .pop_ff(pop_ff), .stop_ff(stop_ff), .wait_ff(wait_ff), .done_ff(done_ff));
   // data space read and write
   assign mem_rdata = mem[mem_raddr];
   always @(posedge clk) if (mem_wr_ff.we) mem[mem_wr_ff.addr] <= mem_wr_ff.data;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [19:0] e, s);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // offer one instruction, hold it over the taking edge, wait for done
   task automatic op(input abce_pkg::abce_op_t o, input logic u, d, input logic [7:0] a, i,
                     input logic [2:0] b, input logic [11:0] t);
      int n;
      n = 0;
      ins = '{op: o, use_imm: u, dst_acc: d, addr: a, imm: i, bit_sel: b, disp5: t[4:0],
              disp8: t[7:0], target: t};
      @(posedge clk);
      instr <= ins;
      instr_pc <= pcv;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      @(negedge clk);
      while (done_ff !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("done", 1'b1, done_ff);
      pulses = {pc_load_ff, push_ff, pop_ff, stop_ff, wait_ff};
      @(negedge clk);
   endtask
   task automatic alu(input abce_pkg::abce_op_t o, input logic u, d, input logic [7:0] i,
                      input logic [9:0] e);
      op(o, u, d, 8'h3C, i, 3'h0, 12'h000);
      chk("zc_acc", {10'h000, e}, {10'h000, zero_ff, carry_ff, acc_ff});
   endtask
   task automatic t_alu();
      mem[8'h3C] = 8'h20;
      alu(abce_pkg::clear_op, 1'b0, 1'b1, 8'h00, 10'h200);
      alu(abce_pkg::ABCE_OP_ADD, 1'b1, 1'b0, 8'hF0, 10'h0F0);
      alu(abce_pkg::ABCE_OP_ADD, 1'b0, 1'b0, 8'h00, 10'h110);
      alu(abce_pkg::compare_op, 1'b1, 1'b0, 8'h10, 10'h210);
      alu(abce_pkg::ABCE_OP_SUB, 1'b1, 1'b0, 8'h11, 10'h1FF);
      alu(abce_pkg::ABCE_OP_AND, 1'b0, 1'b0, 8'h00, 10'h120);
      alu(abce_pkg::rotate_left_carry_op, 1'b1, 1'b0, 8'hFF, 10'h041);
      alu(abce_pkg::shift_left_arith_op, 1'b1, 1'b0, 8'hFF, 10'h082);
      op(abce_pkg::complement_op, 1'b1, 1'b0, 8'h3C, 8'hFF, 3'h0, 12'h000);
      chk("com", 8'h7D, acc_ff);
      $display("alu test done");
   endtask
   task automatic t_mem();
      c = carry_ff;
      mem[8'hFF] = 8'h00;
      op(abce_pkg::decrement_op, 1'b0, 1'b0, 8'hFF, 8'h00, 3'h0, 12'h000);
      chk("dec", {1'b0, c, 8'hFF}, {zero_ff, carry_ff, mem[8'hFF]});
      op(abce_pkg::ABCE_OP_INC, 1'b0, 1'b0, 8'hFF, 8'h00, 3'h0, 12'h000);
      chk("inc", {1'b1, c, 8'h00}, {zero_ff, carry_ff, mem[8'hFF]});
      // plain ram bytes only: no port or odd-access register under bit ops
      mem[8'h80] = 8'h5A;
      mem[8'h81] = 8'hFF;
      op(abce_pkg::clear_op, 1'b0, 1'b0, 8'h80, 8'h00, 3'h0, 12'h000);
      op(abce_pkg::ABCE_OP_BSET, 1'b0, 1'b0, 8'h80, 8'h00, 3'h7, 12'h000);
      op(abce_pkg::bit_clear_op, 1'b0, 1'b0, 8'h81, 8'h00, 3'h0, 12'h000);
      chk("bits", 16'h80FE, {mem[8'h80], mem[8'h81]});
      chk("bit_flags", {1'b1, c}, {zero_ff, carry_ff});
      chk("acc", 8'h7D, acc_ff);
      // increment aimed at the accumulator leaves the data byte alone
      op(abce_pkg::ABCE_OP_INC, 1'b0, 1'b1, 8'hFF, 8'h00, 3'h0, 12'h000);
      chk("inc_acc", {1'b0, c, 16'h7E00}, {zero_ff, carry_ff, acc_ff, mem[8'hFF]});
      $display("memory test done");
   endtask
   task automatic t_branch();
      alu(abce_pkg::clear_op, 1'b0, 1'b1, 8'h00, 10'h200);
      pcv = 12'h100;
      for (int k = 0; k < 4; k++) begin
         op(abce_pkg::abce_op_t'(5'h0A + 5'(k)), 1'b0, 1'b0, 8'h00, 8'h00, 3'h0,
            k[0] ? 12'h00F : 12'h01F);
         chk("jr_load", (k == 1 || k == 2), pulses[4]);
         if (k == 1 || k == 2) chk("jr_tgt", k[0] ? 12'h110 : 12'h0F1, pc_target_ff);
      end
      mem[8'h22] = 8'h04;
      op(abce_pkg::branch_if_bit_set, 1'b0, 1'b0, 8'h22, 8'h00, 3'h2, 12'h07F);
      chk("bit_set", 3'b111, {pulses[4], zero_ff, carry_ff});
      chk("bit_set_tgt", 12'h181, pc_target_ff);
      op(abce_pkg::branch_if_bit_clear, 1'b0, 1'b0, 8'h22, 8'h00, 3'h3, 12'h080);
      chk("bit_clr", 3'b110, {pulses[4], zero_ff, carry_ff});
      chk("bit_clr_tgt", 12'h082, pc_target_ff);
      op(abce_pkg::branch_if_bit_clear, 1'b0, 1'b0, 8'h22, 8'h00, 3'h2, 12'h080);
      chk("bit_fall", 3'b011, {pulses[4], zero_ff, carry_ff});
      $display("branch test done");
   endtask
   task automatic t_ctrl();
      @(posedge clk);
      ret_addr <= 12'hABC;
      interrupt_return_op_c <= 1'b0; // saved carry differs from the live carry; saved zero differs from the live zero
      op(abce_pkg::long_jump_op, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0, 12'hFFF);
      chk("jump", {5'h10, 12'hFFF}, {pulses, pc_target_ff});
      op(abce_pkg::ABCE_OP_CALL, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0, 12'h123);
      chk("call", {5'h18, 12'h123}, {pulses, pc_target_ff});
      op(abce_pkg::no_operation, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0, 12'h000);
      chk("nop", 5'h00, pulses);
      op(abce_pkg::ABCE_OP_RET, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0, 12'h000);
      chk("ret", {5'h14, 12'hABC}, {pulses, pc_target_ff});
      op(abce_pkg::interrupt_return_op, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0, 12'h000);
      chk("interrupt_return_op", {2'b00, 5'h14}, {zero_ff, carry_ff, pulses});
      op(abce_pkg::ABCE_OP_STOP, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0, 12'h000);
      chk("stop", 5'h02, pulses);
      op(abce_pkg::ABCE_OP_WAIT, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0, 12'h000);
      chk("wait", 5'h01, pulses);
      $display("control test done");
   endtask
   task automatic final_report();
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // watchdog: the run needs well under 20 us
   initial begin
      #20000;
      error_cnt++;
      final_report();
   end
   initial begin
      {rst_b, instr_valid, interrupt_return_op_z, interrupt_return_op_c} = 4'h0;
      instr = '0;
      ins = '0;
      {instr_pc, pcv, ret_addr} = 36'h0;
      foreach (mem[j]) mem[j] = 8'h00;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      t_alu();
      t_mem();
      t_branch();
      t_ctrl();
      final_report();
   end
endmodule
bind abce_exec abce_exec_properties u_props (.clk(clk), .rst_b(rst_b),
   .instr_valid(instr_valid), .instr_ready(instr_ready), .instr(instr), .instr_pc(instr_pc),
   .mem_rdata(mem_rdata), .zero_ff(zero_ff), .carry_ff(carry_ff), .pc_load_ff(pc_load_ff),
   .pc_target_ff(pc_target_ff), .done_ff(done_ff));
`default_nettype wire
